// ==== rtl/rhp2_pkg.sv ====
// constants shared by the root port two status and control block
package rhp2_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses, word aligned)
   // ----------------------------------------------------------------
   localparam logic [3:0] RHP2_ADDR_PORT = 4'h0;
   localparam logic [3:0] RHP2_ADDR_IRQ_STAT = 4'h4;
   localparam logic [3:0] RHP2_ADDR_IRQ_MASK = 4'h8;
   localparam logic [3:0] RHP2_ADDR_CONFIG = 4'hC;
   localparam int RHP2_ADDR_W = 4;

   // ----------------------------------------------------------------
   // port status and control field positions
   // ----------------------------------------------------------------
   localparam int RHP2_B_CONN = 0;
   localparam int RHP2_B_ENA = 1;
   localparam int RHP2_B_SUSP = 2;
   localparam int RHP2_B_OVC = 3;
   localparam int RHP2_B_RST = 4;
   localparam int RHP2_B_PWR = 8;
   localparam int RHP2_B_LSDA = 9;
   localparam int RHP2_B_CSC = 16;
   localparam int RHP2_B_ENABLE_CHANGE_FLAG = 17;
   localparam int RHP2_B_SUSPEND_CHANGE_FLAG = 18;
   localparam int RHP2_B_OVERCURRENT_CHANGE_FLAG = 19;
   localparam int RHP2_B_PORT_RESET_CHANGE_FLAG = 20;

   // interrupt status and mask layout
   localparam int RHP2_IRQ_W = 4;
   localparam int RHP2_I_CONN = 0;
   localparam int RHP2_I_ENA = 1;
   localparam int RHP2_I_SUSP = 2;
   localparam int RHP2_I_RST = 3;

   // config register: bit 0 marks a nonremovable device
   localparam int RHP2_C_NONREM = 0;

   localparam logic [31:0] RHP2_ZERO = 32'h0000_0000;
   localparam logic [RHP2_IRQ_W-1:0] RHP2_IRQ_NONE = 4'h0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int RHP2_CLK_NS = 8;
   localparam int RHP2_RESET_MS = 10;
   localparam int RHP2_RESUME_MS = 20;
   localparam int RHP2_LS_EOP_NS = 1334;
   localparam int RHP2_SYNC_MS = 3;
   localparam int RHP2_RESET_CYC = RHP2_RESET_MS * 1000000 / RHP2_CLK_NS;
   localparam int RHP2_RESUME_CYC = RHP2_RESUME_MS * 1000000 / RHP2_CLK_NS;
   localparam int RHP2_LS_EOP_CYC = (RHP2_LS_EOP_NS + RHP2_CLK_NS - 1) / RHP2_CLK_NS;
   localparam int RHP2_SYNC_CYC = RHP2_SYNC_MS * 1000000 / RHP2_CLK_NS;
   localparam int RHP2_CNT_W = 24;
   localparam logic [RHP2_CNT_W-1:0] RHP2_CNT_ZERO = 24'h00_0000;
   localparam logic [RHP2_CNT_W-1:0] RHP2_CNT_ONE = 24'h00_0001;

   // signalling sequencer states
   typedef enum logic [2:0]
   {
      RHP2_ST_IDLE = 3'b000,
      RHP2_ST_RESET = 3'b001,
      RHP2_ST_RESUME = 3'b010,
      RHP2_ST_LS_EOP = 3'b011,
      RHP2_ST_SYNC = 3'b100
   } rhp2_state_t;
endpackage

// ==== rtl/rhp2_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rhp2_pin_sync
   import rhp2_pkg::*;
#(
   parameter int WIDTH = 2
)
(
   // clock and control
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // pins and filtered result
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_stable
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else if (clk_en)
      begin
         s1_r <= pin_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a change counts once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
               pin_stable[i] <= 1'b0;
            else if (clk_en && (s2_r[i] == s3_r[i]))
               pin_stable[i] <= s3_r[i];
         end
      end
   endgenerate
endmodule

// ==== rtl/rhp2_port_ctrl.sv ====
// root hub port two status and control with avalon-mm slave
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module rhp2_port_ctrl
   import rhp2_pkg::*;
#(
   parameter int RESET_CYC = RHP2_RESET_CYC,
   parameter int RESUME_CYC = RHP2_RESUME_CYC,
   parameter int SYNC_CYC = RHP2_SYNC_CYC,
   parameter int LS_EOP_CYC = RHP2_LS_EOP_CYC
)
(
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // avalon-mm slave
   input wire logic [RHP2_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // root hub reset request, same clock domain, level
   input wire logic root_hub_reset,
   // port pins
   input wire logic dev_connect_pin,
   input wire logic dev_low_speed_pin,
   output logic port_reset_drive,
   output logic port_suspend_state,
   output logic port_resume_drive,
   // interrupt
   output logic irq
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [1:0] pins_stable;
   logic conn_pin, ls_pin;
   logic ccs_r, pes_r, pss_r, prs_r, prs_d_r, pps_r, lsda_r;
   logic csc_r, enable_change_flag_r, suspend_change_flag_r, port_reset_change_flag_r, nonrem_r, hub_rst_d_r;
   logic [RHP2_IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt;
   rhp2_state_t state_r;
   logic [RHP2_CNT_W-1:0] cnt_r;
   logic wr_go, wr_port, conn_evt, hub_rst_done, rst_done, resume_done;
   logic [31:0] wmask, wd, port_word;
   logic spr_hit, sps_hit, spe_hit, css_hit, no_conn_hit;

   // write bit decode, used for every w1 field of the port register
   function automatic logic wbit(input logic [31:0] data, input int pos);
      wbit = data[pos];
   endfunction

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   rhp2_pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .pin_async({dev_low_speed_pin, dev_connect_pin}),
      .pin_stable(pins_stable)
   );
   assign conn_pin = pins_stable[0];
   assign ls_pin = pins_stable[1];

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   // waitrequest drops for one cycle per request; the access commits there
   assign wr_go = avs_write && !avs_waitrequest;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wd = avs_writedata & wmask;
   assign wr_port = wr_go && (avs_address == RHP2_ADDR_PORT);
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         avs_waitrequest <= 1'b1;
      else if (clk_en)
         avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
   end

   // port word as software sees it
   always_comb
   begin
      port_word = RHP2_ZERO;
      port_word[RHP2_B_CONN] = ccs_r;
      port_word[RHP2_B_ENA] = pes_r;
      port_word[RHP2_B_SUSP] = pss_r;
      port_word[RHP2_B_RST] = prs_r;
      port_word[RHP2_B_PWR] = pps_r;
      port_word[RHP2_B_LSDA] = lsda_r;
      port_word[RHP2_B_CSC] = csc_r;
      port_word[RHP2_B_ENABLE_CHANGE_FLAG] = enable_change_flag_r;
      port_word[RHP2_B_SUSPEND_CHANGE_FLAG] = suspend_change_flag_r;
      port_word[RHP2_B_OVERCURRENT_CHANGE_FLAG] = 1'b0;
      port_word[RHP2_B_PORT_RESET_CHANGE_FLAG] = port_reset_change_flag_r;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         avs_readdata <= RHP2_ZERO;
      else if (clk_en && avs_read && avs_waitrequest)
      begin
         case (avs_address)
            RHP2_ADDR_PORT: avs_readdata <= port_word;
            RHP2_ADDR_IRQ_STAT: avs_readdata <= {28'h000_0000, irq_stat_r};
            RHP2_ADDR_IRQ_MASK: avs_readdata <= {28'h000_0000, irq_mask_r};
            RHP2_ADDR_CONFIG: avs_readdata <= {31'h0000_0000, nonrem_r};
            default: avs_readdata <= RHP2_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // software requests and sequencer events
   // ----------------------------------------------------------------
   assign spr_hit = wr_port && wbit(wd, RHP2_B_RST);
   assign sps_hit = wr_port && wbit(wd, RHP2_B_SUSP);
   assign spe_hit = wr_port && wbit(wd, RHP2_B_ENA);
   assign css_hit = wr_port && wbit(wd, RHP2_B_OVC);
   assign no_conn_hit = !ccs_r && (spr_hit || sps_hit || spe_hit);
   assign rst_done = (state_r == RHP2_ST_RESET) && (cnt_r == RHP2_CNT_ONE);
   assign resume_done = (state_r == RHP2_ST_SYNC) && (cnt_r == RHP2_CNT_ONE);
   assign hub_rst_done = hub_rst_d_r && !root_hub_reset;
   assign conn_evt = !nonrem_r && (conn_pin != ccs_r);

   // ----------------------------------------------------------------
   // signalling sequencer: reset, resume, eop, sync delay
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || root_hub_reset)
      begin
         state_r <= RHP2_ST_IDLE;
         cnt_r <= RHP2_CNT_ZERO;
      end
      else if (clk_en)
      begin
         case (state_r)
            RHP2_ST_IDLE:
            begin
               if (spr_hit && ccs_r)
               begin
                  state_r <= RHP2_ST_RESET;
                  cnt_r <= RHP2_CNT_W'(RESET_CYC);
               end
               else if (css_hit && pss_r)
               begin
                  state_r <= RHP2_ST_RESUME;
                  cnt_r <= RHP2_CNT_W'(RESUME_CYC);
               end
            end
            RHP2_ST_RESET, RHP2_ST_SYNC:
            begin
               if (cnt_r == RHP2_CNT_ONE)
                  state_r <= RHP2_ST_IDLE;
               cnt_r <= cnt_r - RHP2_CNT_ONE;
            end
            RHP2_ST_RESUME:
            begin
               if (cnt_r == RHP2_CNT_ONE)
               begin
                  state_r <= RHP2_ST_LS_EOP;
                  cnt_r <= RHP2_CNT_W'(LS_EOP_CYC);
               end
               else
                  cnt_r <= cnt_r - RHP2_CNT_ONE;
            end
            RHP2_ST_LS_EOP:
            begin
               if (cnt_r == RHP2_CNT_ONE)
               begin
                  state_r <= RHP2_ST_SYNC;
                  cnt_r <= RHP2_CNT_W'(SYNC_CYC);
               end
               else
                  cnt_r <= cnt_r - RHP2_CNT_ONE;
            end
            default:
            begin
               state_r <= RHP2_ST_IDLE;
               cnt_r <= RHP2_CNT_ZERO;
            end
         endcase
      end
   end

   // pin-facing outputs
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         port_reset_drive <= 1'b0;
         port_resume_drive <= 1'b0;
         port_suspend_state <= 1'b0;
      end
      else if (clk_en)
      begin
         port_reset_drive <= prs_r;
         port_resume_drive <= (state_r == RHP2_ST_RESUME);
         port_suspend_state <= pss_r && (state_r == RHP2_ST_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // port status bits
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         ccs_r <= 1'b0;
         lsda_r <= 1'b0;
         hub_rst_d_r <= 1'b0;
      end
      else if (clk_en)
      begin
         hub_rst_d_r <= root_hub_reset;
         if (nonrem_r)
            ccs_r <= hub_rst_done ? 1'b1 : ccs_r;
         else if (conn_evt)
            ccs_r <= conn_pin;
         lsda_r <= ls_pin && (nonrem_r ? ccs_r : conn_pin);
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || root_hub_reset)
      begin
         pes_r <= 1'b0;
         pss_r <= 1'b0;
         prs_r <= 1'b0;
         prs_d_r <= 1'b0;
      end
      else if (clk_en)
      begin
         prs_d_r <= prs_r;
         // reset status set by software write
         if (spr_hit && ccs_r && (state_r == RHP2_ST_IDLE))
            prs_r <= 1'b1;
         else if (rst_done)
            prs_r <= 1'b0;
         if (conn_evt && !conn_pin)
            pes_r <= 1'b0;
         else if (rst_done || resume_done || (spe_hit && ccs_r))
            pes_r <= 1'b1;
         else if (wr_port && wbit(wd, RHP2_B_CONN))
            pes_r <= 1'b0;
         if (rst_done || resume_done || (conn_evt && !conn_pin))
            pss_r <= 1'b0;
         else if (sps_hit && ccs_r && pes_r)
            pss_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         pps_r <= 1'b0;
      else if (clk_en && wr_port && (wbit(wd, RHP2_B_PWR) || wbit(wd, RHP2_B_LSDA)))
         pps_r <= wbit(wd, RHP2_B_PWR);
   end

   // ----------------------------------------------------------------
   // change flags, set wins over clear
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || root_hub_reset)
      begin
         csc_r <= 1'b0;
         enable_change_flag_r <= 1'b0;
         suspend_change_flag_r <= 1'b0;
         port_reset_change_flag_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (conn_evt || (nonrem_r && hub_rst_done) || no_conn_hit)
            csc_r <= 1'b1;
         else if (wr_port && wbit(wd, RHP2_B_CSC))
            csc_r <= 1'b0;
         if ((conn_evt && !conn_pin && pes_r) || (rst_done && !pes_r))
            enable_change_flag_r <= 1'b1;
         else if (wr_port && wbit(wd, RHP2_B_ENABLE_CHANGE_FLAG))
            enable_change_flag_r <= 1'b0;
         if (resume_done)
            suspend_change_flag_r <= 1'b1;
         else if (wr_port && wbit(wd, RHP2_B_SUSPEND_CHANGE_FLAG))
            suspend_change_flag_r <= 1'b0;
         if (prs_r != prs_d_r)
            port_reset_change_flag_r <= 1'b1;
         else if (wr_port && wbit(wd, RHP2_B_PORT_RESET_CHANGE_FLAG))
            port_reset_change_flag_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // configuration and interrupts
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         nonrem_r <= 1'b0;
      else if (clk_en && wr_go && (avs_address == RHP2_ADDR_CONFIG))
         nonrem_r <= wd[RHP2_C_NONREM];
   end
   always_comb
   begin
      irq_evt = RHP2_IRQ_NONE;
      irq_evt[RHP2_I_CONN] = conn_evt || (nonrem_r && hub_rst_done) || no_conn_hit;
      irq_evt[RHP2_I_ENA] = (conn_evt && !conn_pin && pes_r) || (rst_done && !pes_r);
      irq_evt[RHP2_I_SUSP] = resume_done;
      irq_evt[RHP2_I_RST] = prs_r != prs_d_r;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         irq_stat_r <= RHP2_IRQ_NONE;
         irq_mask_r <= RHP2_IRQ_NONE;
         irq <= 1'b0;
      end
      else if (clk_en)
      begin
         if (wr_go && (avs_address == RHP2_ADDR_IRQ_STAT))
            irq_stat_r <= (irq_stat_r & ~wd[RHP2_IRQ_W-1:0]) | irq_evt;
         else
            irq_stat_r <= irq_stat_r | irq_evt;
         if (wr_go && (avs_address == RHP2_ADDR_IRQ_MASK))
            irq_mask_r <= wd[RHP2_IRQ_W-1:0];
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end
endmodule

// ==== tb/rhp2_port_ctrl_asserts.sv ====
// concurrent checks on the root port two status and control block
`timescale 1ns/1ps
module rhp2_port_ctrl_asserts
   import rhp2_pkg::*;
#(
   parameter int RESET_CYC = 20,
   parameter int RESUME_CYC = 20
)
(
   // clock and resets
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic root_hub_reset,
   // avalon-mm slave
   input wire logic [RHP2_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // port signalling
   input wire logic port_reset_drive,
   input wire logic port_resume_drive
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // ----
   // helper logic
   // ----
   logic wr_rst;
   int rst_len_r;
   int res_len_r;
   assign wr_rst = avs_write && !avs_waitrequest && avs_address == RHP2_ADDR_PORT
                   && avs_writedata[RHP2_B_RST] && avs_byteenable[0];

   // length of the current reset and resume pulses
   always_ff @(posedge core_clk)
      rst_len_r <= (sys_rst || !port_reset_drive) ? 0 : rst_len_r + 1;
   always_ff @(posedge core_clk)
      res_len_r <= (sys_rst || !port_resume_drive) ? 0 : res_len_r + 1;

   sequence s_port_rd;
      avs_read && !avs_waitrequest && avs_address == RHP2_ADDR_PORT;
   endsequence
   sequence s_req_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   a_ovc_zero:
   assert property (s_port_rd |-> avs_readdata[RHP2_B_OVERCURRENT_CHANGE_FLAG] == 1'b0) else $error("overcurrent change read one");
   a_rsvd_zero:
   assert property (s_port_rd |-> avs_readdata[31:21] == 11'h000 && avs_readdata[15:10] == 6'h00)
      else $error("reserved bits read nonzero");
   a_unmapped_zero:
   assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == RHP2_ZERO)
      else $error("unmapped read nonzero");
   a_wait_pulse:
   assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
   a_wait_idle:
   assert property (!avs_read && !avs_write |=> avs_waitrequest) else $error("answer without request");
   a_wait_bound:
   assert property (s_req_wait |-> ##[1:3] !avs_waitrequest) else $error("request not answered");
   a_reset_start:
   assert property ($rose(port_reset_drive) |-> $past(wr_rst) || $past(wr_rst, 2) || $past(wr_rst, 3))
      else $error("reset signalling without request");
   a_reset_length:
   assert property (@(posedge core_clk) disable iff (sys_rst || root_hub_reset)
      $fell(port_reset_drive) |-> rst_len_r >= RESET_CYC - 1 && rst_len_r <= RESET_CYC + 1)
      else $error("reset pulse length wrong");
   a_resume_length:
   assert property (@(posedge core_clk) disable iff (sys_rst || root_hub_reset)
      $fell(port_resume_drive) |-> res_len_r >= RESUME_CYC - 1 && res_len_r <= RESUME_CYC + 1)
      else $error("resume pulse length wrong");
endmodule

bind rhp2_port_ctrl rhp2_port_ctrl_asserts #(.RESET_CYC(RESET_CYC), .RESUME_CYC(RESUME_CYC)) u_asserts
(
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .root_hub_reset(root_hub_reset),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .port_reset_drive(port_reset_drive),
   .port_resume_drive(port_resume_drive)
);

// ==== tb/rhp2_usb_dev.sv ====
// behavioural usb device standing on root port two
`timescale 1ns/1ps
module rhp2_usb_dev
(
   // clock and commands from the bench
   input wire logic core_clk,
   input wire logic attach,
   input wire logic low_speed,
   // host side signalling
   input wire logic port_reset_drive,
   // device pins and observations
   output logic dev_connect_pin,
   output logic dev_low_speed_pin,
   output int resets_seen
);
   logic rst_seen_r;

   initial
   begin
      dev_connect_pin = 1'b0;
      dev_low_speed_pin = 1'b0;
      resets_seen = 0;
      rst_seen_r = 1'b0;
   end

   always @(posedge core_clk)
   begin
      dev_connect_pin <= attach;
      // speed line is pulled low with nothing attached
      dev_low_speed_pin <= attach & low_speed;
      rst_seen_r <= port_reset_drive;
      if (port_reset_drive && !rst_seen_r)
         resets_seen <= resets_seen + 1;
   end
endmodule

// ==== tb/rhp2_port_ctrl_tb.sv ====
// self-checking testbench for the root port two status and control block
`timescale 1ns/1ps
module rhp2_port_ctrl_tb
   import rhp2_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic root_hub_reset = 1'b0;
   logic attach = 1'b0;
   logic low_speed = 1'b0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic dev_connect_pin;
   logic dev_low_speed_pin;
   logic port_reset_drive;
   logic port_suspend_state;
   logic port_resume_drive;
   logic irq;
   logic [31:0] rd;
   int resets_seen;
   int bad_count = 0;
   int check_count = 0;
   int n;
   int set_bits[3] = '{1, 2, 4};

   always #4 core_clk = ~core_clk;

   rhp2_port_ctrl #(.RESET_CYC(20), .RESUME_CYC(20), .SYNC_CYC(20), .LS_EOP_CYC(4)) dut
   (
      .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .root_hub_reset(root_hub_reset),
      .dev_connect_pin(dev_connect_pin), .dev_low_speed_pin(dev_low_speed_pin),
      .port_reset_drive(port_reset_drive), .port_suspend_state(port_suspend_state),
      .port_resume_drive(port_resume_drive), .irq(irq)
   );

   rhp2_usb_dev u_dev
   (
      .core_clk(core_clk), .attach(attach), .low_speed(low_speed), .port_reset_drive(port_reset_drive),
      .dev_connect_pin(dev_connect_pin), .dev_low_speed_pin(dev_low_speed_pin), .resets_seen(resets_seen)
   );

   // ----
   // tasks
   // ----
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task chk_pin(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
      end
      while (avs_waitrequest !== 1'b0 && k < 40);
      if (k >= 40)
         bad_count++;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
      bus(1'b0, a, 32'h0);
      chk_word(what, e, rd & m);
   endtask

   task idle(input int c);
      repeat (c) @(posedge core_clk);
   endtask

   // ----
   // scenarios
   // ----
   initial
   begin
      void'($urandom(32'h77F3));
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      idle(1);
      for (int i = 0; i < 4; i++)
         rd_chk(4'(i * 4), 32'hFFFF_FFFF, 32'h0, "reset value");
      wr(4'hE, 32'hFFFF_FFFF);
      rd_chk(4'hE, 32'hFFFF_FFFF, 32'h0, "unmapped");
      rd_chk(RHP2_ADDR_CONFIG, 32'hFFFF_FFFF, 32'h0, "config after hole");
      for (int i = 0; i < 3; i++)
      begin
         wr(RHP2_ADDR_PORT, 32'h1 << set_bits[i]);
         rd_chk(RHP2_ADDR_PORT, 32'h0001_0017, 32'h0001_0000, "request without device");
         wr(RHP2_ADDR_PORT, 32'h0001_0000);
         rd_chk(RHP2_ADDR_PORT, 32'h0001_0000, 32'h0, "connect change clear");
      end
      wr(RHP2_ADDR_PORT, 32'h100);
      rd_chk(RHP2_ADDR_PORT, 32'h300, 32'h100, "power set");
      wr(RHP2_ADDR_PORT, 32'h0);
      rd_chk(RHP2_ADDR_PORT, 32'h300, 32'h100, "power zero write");
      wr(RHP2_ADDR_PORT, 32'h200);
      rd_chk(RHP2_ADDR_PORT, 32'h300, 32'h0, "power clear");
      for (int i = 0; i < 4; i++)
      begin
         wr(RHP2_ADDR_PORT, $urandom & 32'hFFE0_FC00);
         rd_chk(RHP2_ADDR_PORT, 32'hFFE8_FC00, 32'h0, "reserved bits");
      end
      wr(RHP2_ADDR_IRQ_STAT, 32'hF);
      attach <= 1'b1;
      idle(10);
      rd_chk(RHP2_ADDR_PORT, 32'h001F_0203, 32'h0001_0001, "attach");
      wr(RHP2_ADDR_PORT, 32'h0);
      rd_chk(RHP2_ADDR_PORT, 32'h0001_0000, 32'h0001_0000, "csc zero write");
      avs_byteenable <= 4'hB;
      wr(RHP2_ADDR_PORT, 32'h0001_0000);
      avs_byteenable <= 4'hF;
      rd_chk(RHP2_ADDR_PORT, 32'h0001_0000, 32'h0001_0000, "csc lane masked");
      rd_chk(RHP2_ADDR_IRQ_STAT, 32'hF, 32'h1, "irq status");
      chk_pin("irq masked", 1'b0, irq);
      wr(RHP2_ADDR_IRQ_MASK, 32'h1);
      idle(3);
      chk_pin("irq raised", 1'b1, irq);
      wr(RHP2_ADDR_IRQ_STAT, 32'h1);
      idle(3);
      chk_pin("irq cleared", 1'b0, irq);
      wr(RHP2_ADDR_PORT, 32'h0001_0000);
      wr(RHP2_ADDR_PORT, 32'h10);
      idle(2);
      chk_pin("reset drive", 1'b1, port_reset_drive);
      rd_chk(RHP2_ADDR_PORT, 32'h0010_0010, 32'h0010_0010, "reset running");
      for (n = 0; port_reset_drive !== 1'b0 && n < 100; n++)
         @(posedge core_clk);
      chk_pin("reset ended", 1'b0, port_reset_drive);
      idle(2);
      rd_chk(RHP2_ADDR_PORT, 32'h001F_0017, 32'h0012_0003, "reset done");
      wr(RHP2_ADDR_PORT, 32'h0);
      rd_chk(RHP2_ADDR_PORT, 32'h0010_0000, 32'h0010_0000, "port_reset_change_flag zero write");
      wr(RHP2_ADDR_PORT, 32'h0012_0000);
      rd_chk(RHP2_ADDR_PORT, 32'h0012_0000, 32'h0, "port_reset_change_flag enable_change_flag clear");
      wr(RHP2_ADDR_PORT, 32'h4);
      idle(2);
      chk_pin("suspended", 1'b1, port_suspend_state);
      wr(RHP2_ADDR_PORT, 32'h8);
      idle(2);
      chk_pin("resume drive", 1'b1, port_resume_drive);
      rd_chk(RHP2_ADDR_PORT, 32'h0004_0000, 32'h0, "suspend_change_flag in resume");
      for (n = 0; port_resume_drive !== 1'b0 && n < 100; n++)
         @(posedge core_clk);
      chk_pin("resume ended", 1'b0, port_resume_drive);
      rd_chk(RHP2_ADDR_PORT, 32'h0004_0000, 32'h0, "suspend_change_flag before sync");
      idle(40);
      rd_chk(RHP2_ADDR_PORT, 32'h0004_0004, 32'h0004_0000, "suspend_change_flag after sync");
      wr(RHP2_ADDR_PORT, 32'h0);
      rd_chk(RHP2_ADDR_PORT, 32'h0004_0000, 32'h0004_0000, "suspend_change_flag zero write");
      wr(RHP2_ADDR_PORT, 32'h0004_0000);
      rd_chk(RHP2_ADDR_PORT, 32'h0004_0000, 32'h0, "suspend_change_flag clear");
      attach <= 1'b0;
      idle(10);
      rd_chk(RHP2_ADDR_PORT, 32'h0003_0003, 32'h0003_0000, "detach enabled");
      wr(RHP2_ADDR_PORT, 32'h0003_0000);
      low_speed <= 1'b1;
      attach <= 1'b1;
      idle(10);
      rd_chk(RHP2_ADDR_PORT, 32'h0001_0201, 32'h0001_0201, "low speed attach");
      wr(RHP2_ADDR_CONFIG, 32'h1);
      attach <= 1'b0;
      idle(10);
      wr(RHP2_ADDR_PORT, 32'h0001_0000);
      rd_chk(RHP2_ADDR_PORT, 32'h0001_0000, 32'h0, "pin ignored");
      root_hub_reset <= 1'b1;
      idle(2);
      root_hub_reset <= 1'b0;
      idle(3);
      rd_chk(RHP2_ADDR_PORT, 32'h0001_0001, 32'h0001_0001, "after hub reset");
      chk_word("resets seen", 32'h1, 32'(resets_seen));
      complete_run;
   end

   // the scenarios take well under two thousand cycles
   initial
   begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      complete_run;
   end
endmodule
